// ### core/tick_if.sv
// Purpose: Carries prescaler ticks to the watchdog counter
// Assumes: Single clock domain
// Notes:   Ticks are one-cycle pulses

interface tick_if;
   logic tickFast;
   logic tickSlow;
   logic restart;

   modport src (output tickFast, output tickSlow, input restart);
   modport snk (input tickFast, input tickSlow, output restart);
endinterface

// ### core/watchdog_pkg.sv
// Purpose: Shared constants for the watchdog timer block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Byte address is four times the register index

package watchdog_pkg;

   // Bus geometry
   localparam int          PADDR_W        = 12;
   localparam int          PDATA_W        = 32;

   // Register indices and byte addresses
   localparam logic [11:0] PMC_IDX        = 12'h05E;
   localparam logic [11:0] WDT_IDX        = 12'h060;
   localparam logic [11:0] RATE_IDX       = 12'h061;
   localparam logic [11:0] IRQ_IDX        = 12'h063;
   localparam logic [11:0] PMC_ADDR       = {PMC_IDX[9:0], 2'b00};
   localparam logic [11:0] WDT_ADDR       = {WDT_IDX[9:0], 2'b00};
   localparam logic [11:0] RATE_ADDR      = {RATE_IDX[9:0], 2'b00};
   localparam logic [11:0] IRQ_ADDR       = {IRQ_IDX[9:0], 2'b00};

   // Counter geometry and preload
   localparam int          CNT_W          = 12;
   localparam logic [11:0] CNT_RELOAD     = 12'hFFF;
   localparam logic [11:0] CNT_WRAP       = 12'h800;

   // Processor mode control layout
   localparam int          PMC_W          = 8;
   localparam logic [7:0]  PMC_RESET      = 8'h02;
   localparam int          SOFT_RESET_BIT = 3;

   // Rate select flag and interrupt request flag
   localparam logic        RATE_RESET     = 1'b0;
   localparam int          RATE_BIT       = 0;
   localparam int          IRQ_BIT        = 0;

   // Prescaler ratios
   localparam int          DIV_FAST       = 32;
   localparam int          DIV_SLOW       = 512;

endpackage

// ### core/watchdog_timer.sv
// Purpose: Watchdog down-counter with APB register access
// Assumes: Inputs synchronous to core_clk; APB master keeps protocol
// Notes:   No wait state on any APB transfer
//
// Implementation choice: the APB interface to the registers.

// Operation
// - Counter is a twelve-bit binary down-counter.
// - Count tick comes from the clock divided by 32 or 512.
// - Rate flag 0 selects divide-by-512, 1 selects divide-by-32.
// - Rate flag clears on reset, slow tick in use afterwards.
// - Preload all ones on reset, stop instruction, write, top bit clear.
// - After preload, decrement by one per selected tick.
// - After 2048 ticks top bit clears; set request, reload ones.
// - Writing one to mode bit 3 issues an internal reset pulse.
// - Elevated evaluation level on reset stops the watchdog entirely; here it is not latched at reset, the live level holds the count at preload.
// - Bus hold, DMA or refresh blocks the tick; count holds.
// - Rate flag at index 61h, only bit 0 defined, resets zero.
module watchdog_timer (
   // Clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                nrst,
   // APB slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [watchdog_pkg::PADDR_W-1:0]    paddr,
   input  wire logic [watchdog_pkg::PDATA_W-1:0]    pwdata,
   input  wire logic [3:0]                          pstrb,
   output logic      [watchdog_pkg::PDATA_W-1:0]    prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // Processor events
   input  wire logic                                clockStopInstr,
   input  wire logic                                busHold,
   input  wire logic                                dmaActive,
   input  wire logic                                refreshActive,
   input  wire logic                                evalHighVoltage,
   // Watchdog outputs
   output logic                                     wdtIrqReq,
   output logic                                     softResetPulse
);
   import watchdog_pkg::*;

   tick_if ticks ();

   wdt_prescaler #(
      .DIV_FAST (DIV_FAST),
      .DIV_SLOW (DIV_SLOW)
   ) u_prescaler (
      .core_clk (core_clk),
      .nrst     (nrst),
      .ticks    (ticks)
   );

   logic [CNT_W-1:0]   cnt_reg;
   logic [CNT_W-1:0]   cnt_next;
   logic               rateSel_reg;
   logic [PMC_W-1:0]   pmc_reg;
   logic               irqFlag_reg;
   logic               softReset_reg;
   logic [PDATA_W-1:0] prdata_reg;
   logic               pready_reg;
   logic               pslverr_reg;
   logic               setupPhase;
   logic               accessDone;
   logic               wrDone;
   logic               addrHit;
   logic               cntWrite;
   logic               freeze;
   logic               selTick;
   logic               countEn;
   logic               wrap;
   logic               reloadNow;
   logic               irqClear;

   // APB phase decoding
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && pready_reg;
   assign wrDone     = accessDone && pwrite && !pslverr_reg;
   assign addrHit    = (paddr == PMC_ADDR) || (paddr == WDT_ADDR) ||
                       (paddr == RATE_ADDR) || (paddr == IRQ_ADDR);

   assign cntWrite   = wrDone && (paddr == WDT_ADDR);

   assign irqClear   = wrDone && (paddr == IRQ_ADDR) && pstrb[0] &&
                       pwdata[IRQ_BIT];

   assign freeze     = busHold || dmaActive || refreshActive;

   assign selTick    = rateSel_reg ? ticks.tickFast : ticks.tickSlow;

   assign countEn    = selTick && !freeze;
   assign wrap       = countEn && (cnt_reg == CNT_WRAP);
   assign reloadNow  = evalHighVoltage || clockStopInstr || cntWrite;

   // Restart the prescaler on stop so the next period is whole
   assign ticks.restart = clockStopInstr;

   always_comb begin
      cnt_next = cnt_reg;
      if (reloadNow) begin
         cnt_next = CNT_RELOAD;
      end else if (wrap) begin
         cnt_next = CNT_RELOAD;
      end else if (countEn) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= CNT_RELOAD;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // request flag, set wins over clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irqFlag_reg <= 1'b0;
      end else if (wrap && !reloadNow) begin
         irqFlag_reg <= 1'b1;
      end else if (irqClear) begin
         irqFlag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rateSel_reg <= RATE_RESET;
      end else if (wrDone && (paddr == RATE_ADDR) && pstrb[0]) begin
         rateSel_reg <= pwdata[RATE_BIT];
      end
   end

   // Mode register keeps the reset bit clear; it only fires the pulse
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pmc_reg <= PMC_RESET;
      end else if (wrDone && (paddr == PMC_ADDR) && pstrb[0]) begin
         pmc_reg <= pwdata[PMC_W-1:0] & ~(8'h01 << SOFT_RESET_BIT);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         softReset_reg <= 1'b0;
      end else begin
         softReset_reg <= wrDone && (paddr == PMC_ADDR) && pstrb[0] &&
                          pwdata[SOFT_RESET_BIT];
      end
   end

   // APB answer: registered in setup, presented in access
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setupPhase;
         pslverr_reg <= setupPhase && !addrHit;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_reg <= '0;
      end else if (setupPhase) begin
         prdata_reg <= '0;
         if (!pwrite) begin
            case (paddr)
               PMC_ADDR:  prdata_reg <= {24'h000000, pmc_reg};
               WDT_ADDR:  prdata_reg <= {20'h00000, cnt_reg};
               RATE_ADDR: prdata_reg <= {31'h00000000, rateSel_reg};
               IRQ_ADDR:  prdata_reg <= {31'h00000000, irqFlag_reg};
               default:   prdata_reg <= '0;
            endcase
         end
      end
   end

   assign prdata         = prdata_reg;
   assign pready         = pready_reg;
   assign pslverr        = pslverr_reg;
   assign wdtIrqReq      = irqFlag_reg;
   assign softResetPulse = softReset_reg;

   // Checks
   sequence s_readCnt;
      setupPhase && !pwrite && (paddr == WDT_ADDR);
   endsequence

   sequence s_readRate;
      setupPhase && !pwrite && (paddr == RATE_ADDR);
   endsequence

   sequence s_softWrite;
      wrDone && (paddr == PMC_ADDR) && pstrb[0] && pwdata[SOFT_RESET_BIT];
   endsequence

   sequence s_fastGap;
      ticks.tickFast ##1 (!ticks.tickFast && !ticks.restart) [*8];
   endsequence

   sequence s_readyPulse;
      pready ##1 !pready;
   endsequence

   a_top_bit_set: assert property (
      @(posedge core_clk) disable iff (!nrst) cnt_reg[CNT_W-1])
      else $error("counter top bit seen clear");

   a_slow_has_fast: assert property (
      @(posedge core_clk) disable iff (!nrst)
      ticks.tickSlow |-> ticks.tickFast)
      else $error("slow tick without fast tick");

   a_fast_tick_gap: assert property (
      @(posedge core_clk) disable iff (!nrst)
      ticks.tickFast && !ticks.restart |=> (!ticks.tickFast) [*8])
      else $error("fast ticks too close");

   a_fast_rate_dec: assert property (
      @(posedge core_clk) disable iff (!nrst)
      rateSel_reg && ticks.tickFast && !freeze && !reloadNow &&
      (cnt_reg != CNT_WRAP) |=> cnt_reg == $past(cnt_reg) - 12'h001)
      else $error("fast tick did not decrement");

   a_slow_rate_hold: assert property (
      @(posedge core_clk) disable iff (!nrst)
      !rateSel_reg && !ticks.tickSlow && !reloadNow |=> $stable(cnt_reg))
      else $error("counter moved without slow tick");

   a_rate_reset: assert property (
      @(posedge core_clk) $rose(nrst) |-> !rateSel_reg)
      else $error("rate flag not clear after reset");

   a_write_reload: assert property (
      @(posedge core_clk) disable iff (!nrst)
      cntWrite || clockStopInstr |=> cnt_reg == CNT_RELOAD)
      else $error("reload source did not preload");

   a_wrap_request: assert property (
      @(posedge core_clk) disable iff (!nrst)
      wrap && !reloadNow |=> (cnt_reg == CNT_RELOAD) && wdtIrqReq)
      else $error("wrap did not raise request and reload");

   a_soft_pulse: assert property (
      @(posedge core_clk) disable iff (!nrst)
      s_softWrite |=> softResetPulse ##1 !softResetPulse)
      else $error("soft reset pulse wrong");

   a_eval_stop: assert property (
      @(posedge core_clk) disable iff (!nrst)
      evalHighVoltage |=> (cnt_reg == CNT_RELOAD) && !$rose(wdtIrqReq))
      else $error("watchdog active in evaluation level");

   a_freeze_hold: assert property (
      @(posedge core_clk) disable iff (!nrst)
      freeze && !reloadNow |=> $stable(cnt_reg) && !$rose(wdtIrqReq))
      else $error("counter moved while frozen");

   a_rate_upper_zero: assert property (
      @(posedge core_clk) disable iff (!nrst)
      s_readRate |=> (prdata[PDATA_W-1:1] == '0) &&
      (prdata[0] == $past(rateSel_reg)))
      else $error("rate read wrong");

   a_count_read: assert property (
      @(posedge core_clk) disable iff (!nrst)
      s_readCnt |=> (prdata[CNT_W-1:0] == $past(cnt_reg)) && pready)
      else $error("counter read wrong");

   a_slow_rate_dec: assert property (
      @(posedge core_clk) disable iff (!nrst)
      !rateSel_reg && ticks.tickSlow && !freeze && !reloadNow &&
      (cnt_reg != CNT_WRAP) |=> cnt_reg == $past(cnt_reg) - 12'h001)
      else $error("slow tick did not decrement");

   a_irq_sticky: assert property (
      @(posedge core_clk) disable iff (!nrst)
      wdtIrqReq && !irqClear |=> wdtIrqReq)
      else $error("request flag dropped without clear");

   a_irq_set_wins: assert property (
      @(posedge core_clk) disable iff (!nrst)
      wrap && !reloadNow && irqClear |=> wdtIrqReq)
      else $error("clear beat a new request");

   a_reset_preload: assert property (
      @(posedge core_clk) $rose(nrst) |-> cnt_reg == CNT_RELOAD)
      else $error("counter not preloaded after reset");

   a_rate_write: assert property (
      @(posedge core_clk) disable iff (!nrst)
      wrDone && (paddr == RATE_ADDR) && pstrb[0] |=>
      rateSel_reg == $past(pwdata[RATE_BIT]))
      else $error("rate flag write lost");

   a_apb_answer: assert property (
      @(posedge core_clk) disable iff (!nrst)
      setupPhase |=> s_readyPulse)
      else $error("bus answer not one cycle");

endmodule

// ### core/wdt_prescaler.sv
// Purpose: Divides the system clock into fast and slow watchdog ticks
// Assumes: Both ratios are powers of two, fast below slow
// Notes:   Restart realigns both ticks to a full period

module wdt_prescaler #(
   parameter int DIV_FAST = watchdog_pkg::DIV_FAST,
   parameter int DIV_SLOW = watchdog_pkg::DIV_SLOW
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // Tick outputs
   tick_if.src       ticks
);
   import watchdog_pkg::*;

   localparam int PW = $clog2(DIV_SLOW);
   localparam int FW = $clog2(DIV_FAST);

   if ((DIV_FAST < 2) || (DIV_SLOW <= DIV_FAST) ||
       ((1 << FW) != DIV_FAST) || ((1 << PW) != DIV_SLOW)) begin : g_chk
      $error("wdt_prescaler: ratios must be powers of two, fast < slow");
   end

   logic [PW-1:0] div_reg;
   logic          tickFast_reg;
   logic          tickSlow_reg;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div_reg <= '0;
      end else if (ticks.restart) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tickFast_reg <= 1'b0;
         tickSlow_reg <= 1'b0;
      end else begin
         tickFast_reg <= (div_reg[FW-1:0] == '1) && !ticks.restart;
         tickSlow_reg <= (div_reg == '1) && !ticks.restart;
      end
   end

   assign ticks.tickFast = tickFast_reg;
   assign ticks.tickSlow = tickSlow_reg;

endmodule

// ### dv/testbench.sv
// Purpose: Self-checking bench for the watchdog timer over APB
// Assumes: Full prescaler ratios; fast rate used for the wrap run
// Notes:   Reads compare against counts derived from the tick ratios

module testbench
   import watchdog_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 core_clk        = 1'b0;
   logic                 nrst            = 1'b0;
   logic                 psel            = 1'b0;
   logic                 penable         = 1'b0;
   logic                 pwrite          = 1'b0;
   logic [PADDR_W-1:0]   paddr           = 12'h000;
   logic [PDATA_W-1:0]   pwdata          = 32'h00000000;
   logic [3:0]           pstrb           = 4'hF;
   logic [PDATA_W-1:0]   prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 clockStopInstr  = 1'b0;
   logic                 busHold         = 1'b0;
   logic                 dmaActive       = 1'b0;
   logic                 refreshActive   = 1'b0;
   logic                 evalHighVoltage = 1'b0;
   logic                 wdtIrqReq;
   logic                 softResetPulse;
   int                   fails           = 0;
   int                   total_checks    = 0;
   int                   seed;
   int                   k;
   int                   n;
   logic [31:0]          r;
   logic [31:0]          d;
   logic                 e;

   watchdog_timer u_watchdog_timer (
      .core_clk        (core_clk),
      .nrst            (nrst),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .pstrb           (pstrb),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .clockStopInstr  (clockStopInstr),
      .busHold         (busHold),
      .dmaActive       (dmaActive),
      .refreshActive   (refreshActive),
      .evalHighVoltage (evalHighVoltage),
      .wdtIrqReq       (wdtIrqReq),
      .softResetPulse  (softResetPulse)
   );

   always #12.5 core_clk = ~core_clk;

   task end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Expected count after k ticks from the preload
   function logic [31:0] cntAfter(input int k);
      return {20'h00000, CNT_RELOAD - 12'(k)};
   endfunction

   task waitClk(input int c);
      repeat (c) @(posedge core_clk);
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            input logic [3:0] s, output logic [31:0] rd, output logic er);
      int i;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      pstrb   <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fails++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 4'hF, r, e);
   endtask

   task rdChk(input string name, input logic [11:0] a,
              input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000, 4'hF, r, e);
      check(name, r, exp);
      check("pslverr", {31'h0, e}, 32'h00000000);
   endtask

   task stopPulse();
      @(posedge core_clk);
      clockStopInstr <= 1'b1;
      @(posedge core_clk);
      clockStopInstr <= 1'b0;
   endtask

   initial begin
      seed = 83;
      waitClk(10);
      nrst <= 1'b1;
      rdChk("modeReset", PMC_ADDR, 32'h02);
      rdChk("rateReset", RATE_ADDR, 32'h00);
      rdChk("cntReset", WDT_ADDR, 32'hFFF);
      apb(1'b0, 12'h010, 32'h0, 4'hF, r, e);
      check("unmapErr", {31'h0, e}, 32'h1);
      check("unmapData", r, 32'h0);
      $display("test reset done");
      stopPulse();
      waitClk(3 * DIV_SLOW + DIV_SLOW / 2);
      rdChk("cntSlow", WDT_ADDR, cntAfter(3));
      $display("test slow rate done");
      wr(RATE_ADDR, $random(seed) | 32'h1);
      rdChk("rateFast", RATE_ADDR, 32'h1);
      apb(1'b1, RATE_ADDR, 32'h0, 4'h0, r, e);
      rdChk("rateStrobe", RATE_ADDR, 32'h1);
      for (int i = 0; i < 3; i++) begin
         k = 1 + ($random(seed) & 15);
         stopPulse();
         waitClk(k * DIV_FAST + 8);
         rdChk("cntFast", WDT_ADDR, cntAfter(k));
         wr(WDT_ADDR, $random(seed));
         rdChk("cntWrite", WDT_ADDR, 32'hFFF);
      end
      $display("test fast rate and reload done");
      for (int f = 0; f < 3; f++) begin
         stopPulse();
         waitClk(8);
         {refreshActive, dmaActive, busHold} <= 3'(1 << f);
         waitClk(4 * DIV_FAST);
         rdChk("cntFrozen", WDT_ADDR, 32'hFFF);
         {refreshActive, dmaActive, busHold} <= 3'b000;
      end
      $display("test freeze done");
      stopPulse();
      waitClk(3 * DIV_FAST + 8);
      evalHighVoltage <= 1'b1;
      waitClk(4 * DIV_FAST);
      rdChk("cntEval", WDT_ADDR, 32'hFFF);
      evalHighVoltage <= 1'b0;
      $display("test evaluation level done");
      d = ($random(seed) & 32'hF7) | 32'h08;
      wr(PMC_ADDR, d);
      for (n = 0; n < 3; n++) begin
         #1;
         if (softResetPulse === 1'b1) break;
         @(posedge core_clk);
      end
      check("softPulse", {31'h0, softResetPulse}, 32'h1);
      @(posedge core_clk);
      #1;
      check("softPulseEnd", {31'h0, softResetPulse}, 32'h0);
      rdChk("modeRead", PMC_ADDR, d & 32'hF7);
      $display("test software reset done");
      for (int i = 0; i < 4; i++) begin
         wr(WDT_ADDR, $random(seed));
         waitClk(2000);
         check("irqFed", {31'h0, wdtIrqReq}, 32'h0);
      end
      stopPulse();
      for (n = 0; n < 70000; n++) begin
         @(posedge core_clk);
         #1;
         if (wdtIrqReq === 1'b1) break;
      end
      if (n == 70000) begin
         fails++;
         end_of_test();
      end
      check("wrapTime", 32'(n >= 2048 * DIV_FAST - 3
                         && n <= 2048 * DIV_FAST + 3), 32'h1);
      rdChk("cntWrap", WDT_ADDR, 32'hFFF);
      rdChk("irqFlag", IRQ_ADDR, 32'h1);
      wr(IRQ_ADDR, 32'h1);
      rdChk("irqClear", IRQ_ADDR, 32'h0);
      check("irqPin", {31'h0, wdtIrqReq}, 32'h0);
      $display("test wrap done");
      end_of_test();
   end
endmodule
